// ---- rtl/fault_reply_pkg.sv ----
// Purpose: constants and carriers for the failure notice reply framer
// Assumes: 32-bit frame words, one word per output beat
// Notes: offsets are byte offsets within the reply frame
`default_nettype none
package fault_reply_pkg;
  // ----------------------------------------------------------------
  // Header flags and versions
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_FAIL_REPLY = 8'hE0; // Reply, Fail, Final
  localparam logic [7:0] MAX_VERSION = 8'h01;
  localparam logic [7:0] MIN_VERSION = 8'h01;
  localparam logic [15:0] NO_TIME_LIMIT = 16'hFFFF;
  localparam logic [7:0] NOTICE_SIZE_32 = 8'h09; // words
  localparam logic [7:0] NOTICE_SIZE_64 = 8'h0B;
  localparam logic [7:0] REPORT_SIZE = 8'h05;
  // ----------------------------------------------------------------
  // Word offsets (bytes), 32-bit / 64-bit context
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_TAG_32 = 6'h0C;
  localparam logic [5:0] OFS_TAG_64 = 6'h10;
  localparam logic [5:0] OFS_STATUS_32 = 6'h10;
  localparam logic [5:0] OFS_STATUS_64 = 6'h18;
  localparam logic [5:0] OFS_UNIT_32 = 6'h14;
  localparam logic [5:0] OFS_UNIT_64 = 6'h1C;
  localparam logic [5:0] OFS_PTR_LO_32 = 6'h1C;
  localparam logic [5:0] OFS_PTR_LO_64 = 6'h24;
  localparam logic [5:0] OFS_PTR_HI_32 = 6'h20;
  localparam logic [5:0] OFS_PTR_HI_64 = 6'h26;
  // ----------------------------------------------------------------
  // Severity bits and failure reasons
  // ----------------------------------------------------------------
  localparam int SEV_FORMAT = 0;
  localparam int SEV_ROUTE = 1;
  localparam int SEV_STATE = 2;
  localparam int SEV_CONGEST = 3;
  localparam logic [7:0] FR_SUSPENDED = 8'h81;
  localparam logic [7:0] FR_TERMINATED = 8'h82;
  localparam logic [7:0] FR_CONGESTION = 8'h83;
  localparam logic [7:0] FR_DELIVERY = 8'h84;
  localparam logic [7:0] FR_STATE = 8'h85;
  localparam logic [7:0] FR_AGE_TIMEOUT = 8'h86;
  localparam logic [7:0] FR_ROUTING = 8'h87;
  localparam logic [7:0] FR_BAD_VERSION = 8'h88;
  localparam logic [7:0] FR_BAD_INIT_TAG = 8'h8F;
  localparam logic [7:0] FR_UNKNOWN = 8'hFF;
  localparam logic [7:0] FUNC_FAILED_REPLY_REPORT = 8'h00; // arbitrary value
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic is_reply;
    logic ctx64;
    logic from_driver;
    logic [7:0] original_function_code;
    logic [11:0] initiator_addr;
    logic [11:0] target_addr;
    logic [63:0] initiator_tag;
    logic [7:0] failure_reason;
    logic [15:0] failing_host_unit;
    logic [11:0] failing_processor_ident;
    logic [15:0] delivery_time_limit;
    logic [63:0] frame_ref;
  } fail_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XLATE = 2'b01,
    ST_EMIT = 2'b11
  } state_t;
endpackage
`default_nettype wire

// ---- rtl/fault_reply_builder.sv ----
// Purpose: builds failure notice replies and failed reply report requests
// Assumes: failure events come from logic on the same clock
// Notes: driver handles are turned into frame addresses via a lookup port
//
// Operation
// - Failed delivery or processing makes a failure notice back to the initiator.
// - A failed reply gets a report request to its sender, never a reply.
// - Header flags carry Reply, Fail and Final set.
// - Function field repeats the original function code.
// - Transaction tag word is zero, at 12 or 16.
// - Status word follows header, at 16 or 24.
// - Max supported version is 01h; min reports oldest supported.
// - Severity bits: format, route, state block, congestion.
// - Transport reasons 81h to 87h and FFh.
// - Header validation reasons 88h to 8Fh.
// - Word at 20 or 28 holds host unit and processor ident.
// - Delivery time limit in microseconds; FFFFh means none.
// - Last two words are saved frame pointer low then high.
// - Saved frame belongs to the inbound message queue.
// - Driver handles are translated to inbound frame addresses, except in failed reply reports.
`default_nettype none
module fault_reply_builder (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Failure event
  input wire logic i_fail_valid,
  input wire fault_reply_pkg::fail_req_t i_fail,
  output logic o_fail_ready,
  // Handle translation to inbound frame address
  output logic o_xlate_req,
  output logic [63:0] o_xlate_handle,
  input wire logic i_xlate_done,
  input wire logic [63:0] i_xlate_frame,
  // Reply word stream
  output logic o_word_valid,
  output logic [31:0] o_word,
  output logic [5:0] o_word_offset,
  output logic o_word_last,
  input wire logic i_word_ready
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fault_reply_pkg::state_t st;
    fault_reply_pkg::fail_req_t req;
    logic [3:0] idx;
    logic [31:0] word;
    logic [5:0] ofs;
    logic last;
  } regs_t;
  regs_t r;
  regs_t next_r;

  function automatic logic [7:0] severity_of(input logic [7:0] reason);
    logic [7:0] s;
    s = 8'h00;
    unique case (reason)
      fault_reply_pkg::FR_CONGESTION: s[fault_reply_pkg::SEV_CONGEST] = 1'b1;
      fault_reply_pkg::FR_SUSPENDED,
      fault_reply_pkg::FR_STATE,
      fault_reply_pkg::FR_AGE_TIMEOUT: s[fault_reply_pkg::SEV_STATE] = 1'b1;
      fault_reply_pkg::FR_TERMINATED,
      fault_reply_pkg::FR_DELIVERY,
      fault_reply_pkg::FR_ROUTING,
      fault_reply_pkg::FR_UNKNOWN: s[fault_reply_pkg::SEV_ROUTE] = 1'b1;
      default: s[fault_reply_pkg::SEV_FORMAT] = 1'b1;
    endcase
    return s;
  endfunction

  // Word contents at position idx; both layouts handled here
  function automatic logic [38:0] word_at(input fault_reply_pkg::fail_req_t q,
                                          input logic [3:0] i);
    logic [31:0] w;
    logic [31:0] sw;
    logic [5:0] o;
    logic l;
    w = 32'h0000_0000;
    sw = {q.failure_reason, severity_of(q.failure_reason),
          fault_reply_pkg::MAX_VERSION, fault_reply_pkg::MIN_VERSION};
    o = {i, 2'b00};
    l = 1'b0;
    if (q.is_reply) begin
      unique case (i)
        4'h0: w = {8'h00, fault_reply_pkg::REPORT_SIZE, 8'h00, 8'h00};
        4'h1: w = {fault_reply_pkg::FUNC_FAILED_REPLY_REPORT, q.target_addr,
                   q.initiator_addr};
        4'h2: w = q.initiator_tag[31:0];
        4'h3: w = 32'h0000_0000;
        default: begin
          w = q.frame_ref[31:0];
          l = 1'b1;
        end
      endcase
    end else begin
      unique case (i)
        4'h0: w = {8'h00, q.ctx64 ? fault_reply_pkg::NOTICE_SIZE_64
                   : fault_reply_pkg::NOTICE_SIZE_32,
                   fault_reply_pkg::FLAGS_FAIL_REPLY, 8'h01};
        4'h1: w = {q.original_function_code, q.initiator_addr, q.target_addr};
        4'h2: w = q.initiator_tag[31:0];
        4'h3: begin
          w = q.ctx64 ? q.initiator_tag[63:32] : 32'h0000_0000;
          o = q.ctx64 ? 6'h0C : fault_reply_pkg::OFS_TAG_32;
        end
        4'h4: begin
          // Short layout has no tag high half, so the status word lands here
          w = q.ctx64 ? 32'h0000_0000 : sw;
          o = q.ctx64 ? fault_reply_pkg::OFS_TAG_64 : fault_reply_pkg::OFS_STATUS_32;
        end
        4'h5: begin
          w = sw;
          o = q.ctx64 ? fault_reply_pkg::OFS_STATUS_64 : fault_reply_pkg::OFS_UNIT_32;
          if (!q.ctx64) begin
            w = {q.failing_host_unit, 4'h0, q.failing_processor_ident};
          end
        end
        4'h6: begin
          o = q.ctx64 ? fault_reply_pkg::OFS_UNIT_64 : 6'h18;
          w = q.ctx64 ? {q.failing_host_unit, 4'h0, q.failing_processor_ident}
              : {16'h0000, q.delivery_time_limit};
        end
        4'h7: begin
          o = q.ctx64 ? 6'h20 : fault_reply_pkg::OFS_PTR_LO_32;
          w = q.ctx64 ? {16'h0000, q.delivery_time_limit} : q.frame_ref[31:0];
        end
        4'h8: begin
          o = q.ctx64 ? fault_reply_pkg::OFS_PTR_LO_64 : fault_reply_pkg::OFS_PTR_HI_32;
          w = q.ctx64 ? q.frame_ref[31:0] : q.frame_ref[63:32];
          l = !q.ctx64;
        end
        default: begin
          o = fault_reply_pkg::OFS_PTR_HI_64;
          w = q.frame_ref[63:32];
          l = 1'b1;
        end
      endcase
    end
    return {o, l, w};
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [38:0] cur;
  logic [3:0] first_idx;
  always_comb begin
    next_r = r;
    first_idx = 4'h0;
    cur = word_at(r.req, r.idx);
    unique case (r.st)
      fault_reply_pkg::ST_IDLE: begin
        if (i_fail_valid) begin
          next_r.req = i_fail;
          next_r.idx = first_idx;
          next_r.st = (i_fail.from_driver && !i_fail.is_reply)
                      ? fault_reply_pkg::ST_XLATE : fault_reply_pkg::ST_EMIT;
        end
      end
      fault_reply_pkg::ST_XLATE: begin
        if (i_xlate_done) begin
          next_r.req.frame_ref = i_xlate_frame;
          next_r.st = fault_reply_pkg::ST_EMIT;
        end
      end
      fault_reply_pkg::ST_EMIT: begin
        {next_r.ofs, next_r.last, next_r.word} = cur;
        if (i_word_ready) begin
          if (cur[32]) begin
            next_r.st = fault_reply_pkg::ST_IDLE;
          end else begin
            next_r.idx = r.idx + 4'h1;
          end
        end
      end
      default: next_r.st = fault_reply_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_fail_ready = (r.st == fault_reply_pkg::ST_IDLE);
  assign o_xlate_req = (r.st == fault_reply_pkg::ST_XLATE);
  assign o_xlate_handle = r.req.frame_ref;
  assign o_word_valid = (r.st == fault_reply_pkg::ST_EMIT);
  assign o_word = cur[31:0];
  assign o_word_offset = cur[38:33];
  assign o_word_last = cur[32];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_flags_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_word_valid && !r.req.is_reply && r.idx == 4'h0) |-> o_word[15:13] == 3'b111)
    else $error("failure reply flags wrong");
  a_func_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_word_valid && !r.req.is_reply && r.idx == 4'h1)
    |-> o_word[31:24] == r.req.original_function_code)
    else $error("function code not copied");
  a_tag_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_word_valid && !r.req.is_reply
     && ((r.req.ctx64 && r.idx == 4'h4) || (!r.req.ctx64 && r.idx == 4'h3)))
    |-> o_word == 32'h0000_0000)
    else $error("transaction tag not zero");
  a_max_version: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_word_valid && !r.req.is_reply && o_word_offset == (r.req.ctx64 ? 6'h18 : 6'h10))
    |-> o_word[15:8] == 8'h01 && o_word[31:24] == r.req.failure_reason)
    else $error("status word wrong");
  a_congest_sev: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_word_valid && o_word_offset == 6'h10 && !r.req.ctx64 && !r.req.is_reply
     && r.req.failure_reason == 8'h83) |-> o_word[19:16] == 4'h8)
    else $error("congestion severity wrong");
  a_xlate_ptr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_xlate_req && i_xlate_done) |=> (o_word_valid && r.req.frame_ref == $past(i_xlate_frame)))
    else $error("handle not translated");
  a_event_taken: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_fail_ready && i_fail_valid) |=> !o_fail_ready)
    else $error("failure event lost");
  a_reply_no_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_word_valid && r.req.is_reply && r.idx == 4'h0) |-> o_word[15:8] == 8'h00)
    else $error("failed reply answered with reply");
endmodule // fault_reply_builder
`default_nettype wire

// ---- tb/initiator_model.sv ----
// Purpose: far-side model, translates handles and sinks reply words
// Assumes: same clock as the framer
// Notes: i_slow stalls the sink and delays translation
`default_nettype none
module initiator_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pacing
  input wire logic i_slow,
  // Handle translation
  input wire logic i_xlate_req,
  input wire logic [63:0] i_xlate_handle,
  output logic o_xlate_done,
  output logic [63:0] o_xlate_frame,
  // Reply words
  input wire logic i_word_valid,
  input wire logic [31:0] i_word,
  input wire logic [5:0] i_word_offset,
  input wire logic i_word_last,
  output logic o_word_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cap_word[$];
  logic [5:0] cap_ofs[$];
  logic cap_last[$];
  int frames;
  int waits;
  // ------------------------------------------------------------
  // Translation and sink
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_xlate_done <= 1'b0;
      o_xlate_frame <= 64'h0;
      o_word_ready <= 1'b0;
      waits <= 0;
      frames <= 0;
    end else begin
      o_word_ready <= i_slow ? ~o_word_ready : 1'b1;
      if (i_xlate_req && !o_xlate_done) begin
        waits <= waits + 1;
        if (waits == (i_slow ? 4 : 0)) begin
          o_xlate_done <= 1'b1;
          o_xlate_frame <= {32'h0, 16'h0004, i_xlate_handle[15:0]};
        end
      end else begin
        o_xlate_done <= 1'b0;
        waits <= 0;
        // Stale answer must never look valid
        o_xlate_frame <= ~o_xlate_frame;
      end
      if (i_word_valid && o_word_ready) begin
        cap_word.push_back(i_word);
        cap_ofs.push_back(i_word_offset);
        cap_last.push_back(i_word_last);
        if (i_word_last) begin
          // Saved frame counts as handed back for reuse
          frames <= frames + 1;
        end
      end
    end
  end
endmodule // initiator_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for fault_reply_builder
// Assumes: initiator_model stands on the far side
// Notes: expected frames are built here from the field layout
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_fail_valid, f_rdy, x_req, done, w_val, last, ready, slow;
  fault_reply_pkg::fail_req_t i_fail;
  logic [63:0] handle, frame;
  logic [31:0] word;
  logic [5:0] ofs;
  logic [31:0] ew[$], em[$];
  logic [5:0] eo[$];
  int errors, tests_run, seen, sent;
  fault_reply_builder dut (.i_clk, .i_rst_n, .i_fail_valid, .i_fail, .o_fail_ready(f_rdy),
    .o_xlate_req(x_req), .o_xlate_handle(handle), .i_xlate_done(done), .i_xlate_frame(frame),
    .o_word_valid(w_val), .o_word(word), .o_word_offset(ofs), .o_word_last(last),
    .i_word_ready(ready));
  initiator_model far (.i_clk, .i_rst_n, .i_slow(slow), .i_xlate_req(x_req),
    .i_xlate_handle(handle), .o_xlate_done(done), .o_xlate_frame(frame), .i_word_valid(w_val),
    .i_word(word), .i_word_offset(ofs), .i_word_last(last), .o_word_ready(ready));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic put(input logic [5:0] o, input logic [31:0] w, input logic [31:0] m);
    eo.push_back(o);
    ew.push_back(w & m);
    em.push_back(m);
  endtask
  task automatic expect_frame(input fault_reply_pkg::fail_req_t q);
    logic [63:0] p;
    logic [7:0] sev;
    logic c;
    c = q.ctx64;
    p = q.from_driver ? {48'h4, q.frame_ref[15:0]} : q.frame_ref;
    if (q.is_reply) begin
      put(6'h00, 32'h00050000, 32'h00FF0000);
      put(6'h04, {fault_reply_pkg::FUNC_FAILED_REPLY_REPORT, 24'h0}, 32'hFF000000);
      put(6'h08, 32'h0, 32'h0);
      put(6'h0C, 32'h0, 32'h0);
      put(6'h10, q.frame_ref[31:0], '1);
      return;
    end
    case (q.failure_reason)
      8'h83: sev = 8'h08;
      8'h81, 8'h85, 8'h86: sev = 8'h04;
      8'h82, 8'h84, 8'h87, 8'hFF: sev = 8'h02;
      default: sev = 8'h01;
    endcase
    put(6'h00, {8'h00, c ? 8'h0B : 8'h09, 16'hE001}, 32'h00FFFFFF);
    put(6'h04, {q.original_function_code, q.initiator_addr, q.target_addr}, '1);
    put(6'h08, q.initiator_tag[31:0], '1);
    if (c) put(6'h0C, q.initiator_tag[63:32], '1);
    put(c ? 6'h10 : 6'h0C, 32'h0, '1);
    put(c ? 6'h18 : 6'h10, {q.failure_reason, sev, 16'h0101}, '1);
    put(c ? 6'h1C : 6'h14, {q.failing_host_unit, 4'h0, q.failing_processor_ident},
      32'hFFFF0FFF);
    put(c ? 6'h20 : 6'h18, {16'h0, q.delivery_time_limit}, 32'h0000FFFF);
    put(c ? 6'h24 : 6'h1C, p[31:0], '1);
    put(c ? 6'h26 : 6'h20, p[63:32], '1);
  endtask
  function automatic fault_reply_pkg::fail_req_t mk(input int k);
    fault_reply_pkg::fail_req_t q;
    q = '0;
    q.original_function_code = 8'h20 + 8'(k);
    q.initiator_tag = {32'hC0DE0000 + 32'(k), 32'h5A5A0000 + 32'(k)};
    q.failure_reason = 8'h84;
    q.failing_host_unit = 16'h1200 + 16'(k);
    q.failing_processor_ident = 12'h0A5;
    q.initiator_addr = 12'h3C0 + 12'(k);
    q.target_addr = 12'h0B7;
    q.delivery_time_limit = (k == 0) ? 16'hFFFF : 16'h0100 + 16'(k);
    q.frame_ref = {32'h10000000, 32'h00008000 + 32'(k * 4)};
    return q;
  endfunction
  // Offer one event and wait until it is taken
  task automatic send(input fault_reply_pkg::fail_req_t q);
    int n;
    expect_frame(q);
    sent++;
    @(posedge i_clk);
    i_fail_valid <= 1'b1;
    i_fail <= q;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (f_rdy !== 1'b1 && n < 300);
    @(posedge i_clk);
    i_fail_valid <= 1'b0;
    @(negedge i_clk);
    chk_bit("ready while busy", 1'b0, f_rdy);
    if (!(q.from_driver && !q.is_reply)) chk_bit("answer", 1'b1, w_val);
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (far.frames < sent && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    chk_word("frames", sent, far.frames);
    for (int i = seen; i < eo.size(); i++) begin
      chk_word("offset", 32'(eo[i]), 32'(far.cap_ofs[i]));
      chk_word("word", ew[i], far.cap_word[i] & em[i]);
      chk_bit("last", i + 1 == eo.size() || eo[i + 1] == 6'h00, far.cap_last[i]);
    end
    seen = eo.size();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reasons;
    fault_reply_pkg::fail_req_t q;
    for (int k = 0; k < 16; k++) begin
      q = mk(k);
      q.failure_reason = (k < 15) ? 8'h81 + 8'(k) : 8'hFF;
      send(q);
      drain();
    end
  endtask
  task automatic t_special(input int k, input logic s, input logic c, input logic d,
      input logic rp);
    fault_reply_pkg::fail_req_t q;
    q = mk(k);
    q.ctx64 = c;
    q.from_driver = d;
    q.is_reply = rp;
    @(posedge i_clk);
    slow <= s;
    send(q);
    drain();
  endtask
  task automatic t_busy;
    fault_reply_pkg::fail_req_t q;
    @(posedge i_clk);
    slow <= 1'b1;
    send(mk(50));
    q = mk(51);
    q.failure_reason = 8'h83;
    send(q);
    drain();
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_fail_valid = 1'b0;
    i_fail = '0;
    slow = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_reasons();
    t_special(20, 1'b1, 1'b1, 1'b0, 1'b0);
    t_special(30, 1'b1, 1'b0, 1'b1, 1'b0);
    t_special(31, 1'b0, 1'b1, 1'b1, 1'b0);
    t_special(40, 1'b0, 1'b0, 1'b0, 1'b1);
    t_busy();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    test_done();
  end
  task automatic test_done;
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
endmodule // testbench
`default_nettype wire
